// [verilog/asc_pkg.sv]
// constants, register map and types for the converter sequence control
// assumes one 250 MHz system clock and byte-wide registers on a 32-bit bus
package asc_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL  = 10'h0b4;
  localparam logic [9:0] IDX_SEQ   = 10'h0b5;
  localparam logic [9:0] IDX_EXTRA = 10'h0b6;
  localparam logic [9:0] IDX_LOW   = 10'h0ba;
  localparam logic [9:0] IDX_HIGH  = 10'h0bb;
  localparam logic [9:0] IDX_MASK  = 10'h0f2;
  // reset values
  localparam logic [1:0] START_SOURCE_SEL_RST = 2'h3;
  localparam logic [1:0] RSV_RST   = 2'h3;
  localparam logic [1:0] DECIMATION_SELECT_RST  = 2'h1;
  // start source encodings
  localparam logic [1:0] SRC_PIN   = 2'h0;
  localparam logic [1:0] SRC_FULL  = 2'h1;
  localparam logic [1:0] SRC_TIMER = 2'h2;
  localparam logic [1:0] SRC_SW    = 2'h3;
  // channel code boundaries
  localparam logic [3:0] CH_DIFF0  = 4'h8;
  localparam logic [3:0] CH_FIXED0 = 4'hc;
  localparam int         N_SE      = 8;
  // timing in converter clock periods and divider
  localparam logic [2:0] CLK_DIV     = 3'h6;
  localparam logic [2:0] CLK_HALF    = 3'h3;
  localparam logic [9:0] SETTLE_TCKS = 10'h010;
  localparam logic [9:0] RATE_BASE   = 10'h040;
  // result scaling and limits
  localparam logic [2:0]  SHIFT_MAX = 3'h5;
  localparam logic signed [13:0] RES_MAX = 14'sh07ff;
  localparam logic signed [13:0] RES_MIN = -14'sh0800;
  localparam logic [3:0] RES_BITS [4] = '{4'h7, 4'h9, 4'ha, 4'hc};
  // dma trigger vector: bit k is trigger 20+k
  localparam int N_TRIG   = 9;
  localparam int TRG_FIX  = 8;
  localparam int TRG_SH27 = 7;
  localparam int TRG_SH28 = 8;
  typedef enum logic [1:0] {FS_IDLE, FS_SETTLE, FS_FILT} asc_fsm_e;
endpackage

// [verilog/asc_seq_ctrl.sv]
// sequence, start and result logic of the delta-sigma converter, with
// a classic wishbone slave for its byte-wide control registers.
// assumes the modulator bit and trigger pin are asynchronous, while the
// timer and audio trigger inputs come from logic on sys_clk.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ns
module asc_seq_ctrl
  import asc_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // wishbone slave
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [11:0] wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  // trigger sources
  input  wire logic        external_trigger_pin,
  input  wire logic        timer1_ch0_cmp,
  input  wire logic        audio_trig27,
  input  wire logic        audio_trig28,
  // analogue side
  input  wire logic        mod_bit,
  output logic             mod_clk,
  output logic      [3:0]  ana_channel,
  output logic      [1:0]  ana_ref,
  output logic             ana_busy,
  // events
  output logic             conv_irq,
  output logic [N_TRIG-1:0] dma_trig,
  output logic             any_sample_dma_trigger
);

  // every register of the block lives in this one struct
  typedef struct packed {
    logic              ack;
    logic [7:0]        dat;
    logic              eoc;
    logic              st;
    logic [1:0]        start_source_sel;
    logic [1:0]        rsv;
    logic [1:0]        reference_select;
    logic [1:0]        decimation_select;
    logic [3:0]        sch_wr;
    logic [3:0]        sch_rd;
    logic [7:0]        ext_cfg;
    logic              ext_pend;
    logic [7:0]        mask;
    logic [11:0]       res;
    asc_fsm_e          fsm;
    logic [3:0]        ch;
    logic [1:0]        cur_ref;
    logic [1:0]        cur_div;
    logic              is_extra;
    logic [2:0]        div_cnt;
    logic              mclk;
    logic [9:0]        cnt;
    logic [9:0]        ones;
    logic [N_TRIG-1:0] trig;
    logic              any;
    logic              irq;
    logic              busy;
    logic              ext_s1;
    logic              ext_s2;
    logic              ext_d;
    logic              mod_s1;
    logic              mod_s2;
  } asc_state_s;

  asc_state_s s, n;

  // lowest enabled channel code in [lo, hi]; bit 4 flags success
  function automatic logic [4:0] pick(input logic [3:0] lo, input logic [3:0] hi,
                                      input logic [7:0] m);
    logic [4:0] r;
    logic       en;
    r = 5'h00;
    // scan downward so the lowest enabled code is the one kept
    for (int i = 15; i >= 0; i--)
    begin
      if (i < N_SE)
        en = m[i];
      else if (i < 12)
        en = m[2*(i-N_SE)] & m[2*(i-N_SE)+1];
      else
        en = 1'b1;
      if (en && 4'(i) >= lo && 4'(i) <= hi)
        r = {1'b1, 4'(i)};
    end
    return r;
  endfunction

  logic        rd_ev;
  logic        wr_ev;
  logic [9:0]  idx;
  logic        tick;
  logic [9:0]  rate;
  logic [9:0]  onesf;
  logic [3:0]  first;
  logic [4:0]  nxt_ch;
  logic        start;
  logic        single_end;
  logic signed [13:0] dv;
  logic [11:0] rmask;

  // decode helpers
  always_comb
  begin
    idx        = wb_adr[11:2];
    // side effects only on the edge where the master samples ack high
    rd_ev      = wb_cyc & wb_stb & ~wb_we & s.ack;
    wr_ev      = wb_cyc & wb_stb & wb_we & s.ack & wb_sel[0];
    tick       = (s.div_cnt == 3'h0);
    rate       = RATE_BASE << s.cur_div;
    onesf      = s.ones + {9'h000, s.mod_s2};
    single_end = (s.ch < CH_DIFF0) | (s.ch >= CH_FIXED0);
    // sequence walk origin per channel code range
    if (s.sch_wr < CH_DIFF0)
      first = 4'h0;
    else if (s.sch_wr < CH_FIXED0)
      first = CH_DIFF0;
    else
      first = s.sch_wr;
    // scale ones density to a signed 12-bit value
    // full scale lands on 2048, so the saturation is part of normal use
    dv = $signed({3'h0, onesf, 1'b0}) - $signed({4'h0, rate});
    dv = dv <<< (SHIFT_MAX - {1'b0, s.cur_div});
    if (dv > RES_MAX)
      dv = RES_MAX;
    else if (dv < RES_MIN)
      dv = RES_MIN;
    if (single_end && dv < 0)
      dv = 14'sh0000;
    rmask = 12'hfff << (4'hc - RES_BITS[s.cur_div]);
    // start decision for the selected source
    // pin and timer events while busy are dropped, not queued
    case (s.start_source_sel)
      SRC_PIN:   start = s.ext_s2 & ~s.ext_d;
      SRC_FULL:  start = 1'b1;
      SRC_TIMER: start = timer1_ch0_cmp;
      default:   start = s.st;
    endcase
  end

  // next state: bus, synchronisers, divider, conversion engine
  always_comb
  begin
    n        = s;
    nxt_ch   = 5'h00;
    // registered ack: one wait state, and it falls the cycle after it rose
    n.ack    = wb_cyc & wb_stb & ~s.ack;
    n.irq    = 1'b0;
    n.any    = 1'b0;
    // audio triggers share the top two lines of the trigger vector
    n.trig   = '0;
    n.trig[TRG_SH27] = audio_trig27;
    n.trig[TRG_SH28] = audio_trig28;
    // metastability: first stage feeds only the second
    n.ext_s1 = external_trigger_pin;
    n.ext_s2 = s.ext_s1;
    n.ext_d  = s.ext_s2;
    n.mod_s1 = mod_bit;
    n.mod_s2 = s.mod_s1;
    // divide by six, square output
    n.div_cnt = (s.div_cnt == CLK_DIV - 3'h1) ? 3'h0 : s.div_cnt + 3'h1;
    n.mclk    = (n.div_cnt < CLK_HALF);
    // read mux, captured as ack rises
    if (n.ack)
    begin
      case (idx)
        IDX_CTRL:  n.dat = {s.eoc, s.st, s.start_source_sel, 2'h0, s.rsv};
        IDX_SEQ:   n.dat = {s.reference_select, s.decimation_select, s.sch_rd};
        IDX_EXTRA: n.dat = s.ext_cfg;
        IDX_LOW:   n.dat = {s.res[3:0], 4'h0};
        IDX_HIGH:  n.dat = s.res[11:4];
        IDX_MASK:  n.dat = s.mask;
        default:   n.dat = 8'h00;
      endcase
    end
    // clear first so a completion in the same cycle wins
    if (rd_ev && idx == IDX_HIGH)
      n.eoc = 1'b0;
    case (s.fsm)
      FS_IDLE:
      begin
        if (s.ext_pend)
        begin
          // pending extra beats any sequence trigger
          // a second extra write before this point replaces the first request
          n.ext_pend = 1'b0;
          n.is_extra = 1'b1;
          n.ch       = s.ext_cfg[3:0];
          n.cur_ref  = s.ext_cfg[7:6];
          n.cur_div  = s.ext_cfg[5:4];
          n.cnt      = 10'h000;
          n.fsm      = FS_SETTLE;
        end
        else if (start)
        begin
          // reference and rate are latched per conversion, so a change
          // made while busy only reaches the following conversion
          nxt_ch     = pick(first, s.sch_wr, s.mask);
          if (nxt_ch[4])
          begin
            n.ch      = nxt_ch[3:0];
            n.cur_ref = s.reference_select;
            n.cur_div = s.decimation_select;
            n.cnt     = 10'h000;
            n.fsm     = FS_SETTLE;
          end
          else
          begin
            // nothing enabled: report as if the walk had run
            n.st     = 1'b0;
            n.eoc    = 1'b1;
            n.sch_rd = (s.sch_wr < CH_FIXED0) ? s.sch_wr + 4'h1 : s.sch_wr;
          end
        end
      end
      // settling counts whole converter periods from the first tick
      FS_SETTLE:
      begin
        if (tick)
        begin
          n.cnt = s.cnt + 10'h001;
          if (s.cnt == SETTLE_TCKS - 10'h001)
          begin
            n.cnt  = 10'h000;
            n.ones = 10'h000;
            n.fsm  = FS_FILT;
          end
        end
      end
      FS_FILT:
      begin
        if (tick)
        begin
          n.cnt  = s.cnt + 10'h001;
          n.ones = onesf;
          if (s.cnt == rate - 10'h001)
          begin
            n.res = 12'(dv) & rmask;
            n.eoc = 1'b1;
            n.fsm = FS_IDLE;
            // extra results raise only the interrupt, never a dma trigger
            if (s.is_extra)
            begin
              n.is_extra = 1'b0;
              n.irq      = 1'b1;
              n.sch_rd   = s.ch;
            end
            else
            begin
              n.any      = 1'b1;
              if (s.ch < CH_DIFF0)
                n.trig[s.ch[2:0]] = 1'b1;
              else
                n.trig[TRG_FIX] = 1'b1;
              n.sch_rd = (s.ch < CH_FIXED0) ? s.ch + 4'h1 : s.ch;
              if (s.ch != s.sch_wr)
                nxt_ch = pick(s.ch + 4'h1, s.sch_wr, s.mask);
              if (nxt_ch[4])
              begin
                n.ch      = nxt_ch[3:0];
                n.cur_ref = s.reference_select;
                n.cur_div = s.decimation_select;
                n.cnt     = 10'h000;
                n.fsm     = FS_SETTLE;
              end
              else
              begin
                // sequence over; a pending extra goes next from idle
                n.st     = 1'b0;
                n.sch_rd = (s.sch_wr < CH_FIXED0) ? s.sch_wr + 4'h1 : s.sch_wr;
              end
            end
          end
        end
      end
      default: n.fsm = FS_IDLE;
    endcase
    // writes take effect on the edge the master sees ack
    if (wr_ev)
    begin
      case (idx)
        IDX_CTRL:
        begin
          // write-one bit: a zero write must not undo the end-of-sequence clear
          n.st    = n.st | wb_dat_w[6];
          n.start_source_sel = wb_dat_w[5:4];
          n.rsv   = wb_dat_w[1:0];
        end
        IDX_SEQ:
        begin
          n.reference_select   = wb_dat_w[7:6];
          n.decimation_select   = wb_dat_w[5:4];
          n.sch_wr = wb_dat_w[3:0];
          n.sch_rd = wb_dat_w[3:0];
        end
        IDX_EXTRA:
        begin
          n.ext_cfg  = wb_dat_w[7:0];
          n.ext_pend = 1'b1;
        end
        IDX_MASK: n.mask = wb_dat_w[7:0];
        default: n.mask = n.mask; // low, high and unmapped are read only
      endcase
    end
    // busy follows the next state, so ana_busy drops with the last result
    n.busy = (n.fsm != FS_IDLE);
    if (rst)
    begin
      n       = '0;
      n.fsm   = FS_IDLE;
      // divider parked one before wrap so the first mod_clk high phase is full
      n.div_cnt = CLK_DIV - 3'h1;
      n.start_source_sel = START_SOURCE_SEL_RST;
      n.rsv   = RSV_RST;
      n.decimation_select  = DECIMATION_SELECT_RST;
    end
  end

  // single state register, reset folded into the next value
  always_ff @(posedge sys_clk)
  begin
    s <= n;
  end

  // outputs straight from state flops
  assign wb_dat_r               = {24'h000000, s.dat};
  assign wb_ack                 = s.ack;
  assign mod_clk                = s.mclk;
  assign ana_channel            = s.ch;
  assign ana_ref                = s.cur_ref;
  assign ana_busy               = s.busy;
  assign conv_irq               = s.irq;
  assign dma_trig               = s.trig;
  assign any_sample_dma_trigger = s.any;

endmodule

// [test/asc_mod_model.sv]
// behavioural modulator standing at the converter's analogue side
// assumes the block paces it with mod_clk and reports the channel on ana_channel
`timescale 1ns/1ns
module asc_mod_model
(
  // pacing from the block
  input  wire logic       sys_clk,
  input  wire logic       mod_clk,
  input  wire logic [3:0] ana_channel,
  // bitstream to the block
  output logic            mod_bit
);
  logic mod_clk_q;
  initial mod_bit = 1'b0;
  // inputs give full scale; fixed codes toggle so no stale level sits on the line
  always @(posedge sys_clk)
  begin
    mod_clk_q <= mod_clk;
    if (mod_clk && !mod_clk_q)
      mod_bit <= (ana_channel < 4'hc) ? 1'b1 : ~mod_bit;
  end
endmodule

// [test/asc_seq_monitor.sv]
// concurrent checks on the sequence control ports
// assumes one clock domain and synchronous active-high reset
`timescale 1ns/1ns
module asc_seq_monitor
  import asc_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              wb_cyc,
  input wire logic              wb_stb,
  input wire logic              wb_ack,
  input wire logic [31:0]       wb_dat_r,
  input wire logic              audio_trig27,
  input wire logic              audio_trig28,
  input wire logic              mod_clk,
  input wire logic              ana_busy,
  input wire logic              conv_irq,
  input wire logic [N_TRIG-1:0] dma_trig,
  input wire logic              any_sample_dma_trigger
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // converter clock phases: three cycles high then three low
  sequence s_tick_hi;
    mod_clk [*3];
  endsequence
  sequence s_tick_lo;
    !mod_clk [*3];
  endsequence
  a_tick_divide_six: assert property ($rose(mod_clk) |-> s_tick_hi ##1 s_tick_lo)
    else $error("converter clock not sys_clk over six");
  a_ack_one_late: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("bus ack missing one cycle after request");
  a_ack_one_pulse: assert property (wb_ack |=> !wb_ack)
    else $error("bus ack longer than one cycle");
  a_rdata_byte_only: assert property (wb_ack |-> wb_dat_r[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_extra_no_dma: assert property (conv_irq |-> dma_trig == '0 && !any_sample_dma_trigger)
    else $error("dma trigger with extra conversion end");
  a_any_has_chan: assert property (any_sample_dma_trigger |-> dma_trig != '0)
    else $error("common trigger without channel trigger");
  a_chan_has_any: assert property (dma_trig[6:0] != 7'h0 |-> any_sample_dma_trigger)
    else $error("channel trigger without common trigger");
  a_audio_merge: assert property (audio_trig27 && audio_trig28 |=> dma_trig[8:7] == 2'h3)
    else $error("audio triggers not merged");
  a_busy_min_span: assert property ($rose(ana_busy) |-> ana_busy [*8])
    else $error("conversion ended too early");
  a_irq_one_pulse: assert property (conv_irq |=> !conv_irq)
    else $error("interrupt longer than one cycle");
  // shortest busy span: first tick within six cycles, then settle plus slowest-free rate
  localparam int MIN_CONV = (int'(RATE_BASE) + int'(SETTLE_TCKS)) * int'(CLK_DIV)
                            - int'(CLK_DIV) + 1;
  int busy_len;
  always @(posedge sys_clk)
  begin
    if (rst || !ana_busy)
      busy_len <= 0;
    else
      busy_len <= busy_len + 1;
  end
  a_conv_min_time: assert property ($fell(ana_busy) |-> busy_len >= MIN_CONV)
    else $error("conversion shorter than settle plus rate");
endmodule
bind asc_seq_ctrl asc_seq_monitor i_mon (.sys_clk(sys_clk), .rst(rst), .wb_cyc(wb_cyc),
  .wb_stb(wb_stb), .wb_ack(wb_ack), .wb_dat_r(wb_dat_r), .audio_trig27(audio_trig27),
  .audio_trig28(audio_trig28), .mod_clk(mod_clk), .ana_busy(ana_busy), .conv_irq(conv_irq),
  .dma_trig(dma_trig), .any_sample_dma_trigger(any_sample_dma_trigger));

// [test/asc_seq_ctrl_test.sv]
// self-checking bench: wishbone register tasks, start-bit and extra conversions
// assumes the modulator model gives full scale on analogue inputs
`timescale 1ns/1ns
module asc_seq_ctrl_test;
  import asc_pkg::*;
  logic              sys_clk, rst, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [11:0]       wb_adr;
  logic [3:0]        wb_sel;
  logic [31:0]       wb_dat_w, wb_dat_r, rd;
  logic              pin, tmr, aud27, aud28, mod_bit, mod_clk, ana_busy, conv_irq, any_s;
  logic              seen_clr;
  logic [3:0]        ana_channel;
  logic [1:0]        ana_ref;
  logic [N_TRIG-1:0] dma_trig, seen;
  int                n_mismatch = 0, checked = 0, n_any = 0, n_irq = 0, cyc_cnt = 0;
  asc_seq_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .external_trigger_pin(pin),
    .timer1_ch0_cmp(tmr), .audio_trig27(aud27), .audio_trig28(aud28), .mod_bit(mod_bit),
    .mod_clk(mod_clk), .ana_channel(ana_channel), .ana_ref(ana_ref), .ana_busy(ana_busy),
    .conv_irq(conv_irq), .dma_trig(dma_trig), .any_sample_dma_trigger(any_s));
  asc_mod_model i_mod (.sys_clk(sys_clk), .mod_clk(mod_clk), .ana_channel(ana_channel),
    .mod_bit(mod_bit));
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // event counters; the timeout guards every polling loop below
  always @(posedge sys_clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (any_s === 1'b1) n_any <= n_any + 1;
    if (conv_irq === 1'b1) n_irq <= n_irq + 1;
    seen <= seen_clr ? '0 : seen | dma_trig;
    if (cyc_cnt == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled, then released for a cycle
  task automatic bus(input logic we, input logic [9:0] idx, input logic [7:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'h0};
    wb_dat_w <= {24'h0, d};
    do @(posedge sys_clk); while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge sys_clk);
  endtask
  // poll the control register until the start bit drops and done is up
  task automatic wait_done();
    do bus(1'b0, IDX_CTRL, 8'h0); while (rd[7:6] !== 2'h2);
  endtask
  // empty the trigger record; only the event process writes seen
  task automatic clr_seen();
    seen_clr <= 1'b1;
    @(posedge sys_clk);
    seen_clr <= 1'b0;
  endtask
  initial
  begin
    {wb_cyc, wb_stb, wb_we, pin, tmr, aud27, aud28} = '0;
    {wb_adr, wb_dat_w} = '0;
    wb_sel = 4'hf;
    seen_clr = 1'b1;
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    seen_clr <= 1'b0;
    @(posedge sys_clk);
    bus(1'b0, IDX_CTRL, 8'h0); chk(rd, 32'h33);
    bus(1'b0, IDX_SEQ, 8'h0); chk(rd, 32'h10);
    bus(1'b1, IDX_LOW, 8'hff);
    bus(1'b0, IDX_LOW, 8'h0); chk(rd, 32'h0);
    bus(1'b0, 10'h0, 8'h0); chk(rd, 32'h0);
    bus(1'b1, IDX_MASK, 8'hff);
    // three singles at rate 64, started by the start bit
    bus(1'b1, IDX_SEQ, 8'h02);
    bus(1'b1, IDX_CTRL, 8'h73);
    wait_done();
    chk(n_any, 3);
    chk({23'h0, seen}, 32'h7);
    bus(1'b0, IDX_SEQ, 8'h0); chk(rd, 32'h03);
    bus(1'b0, IDX_LOW, 8'h0); chk(rd, 32'h0);
    bus(1'b0, IDX_HIGH, 8'h0); chk(rd, 32'h7e);
    bus(1'b0, IDX_CTRL, 8'h0); chk(rd[7], 1'b0);
    // extra conversion from idle on a fixed code above the sequence end
    clr_seen();
    bus(1'b1, IDX_EXTRA, 8'h0c);
    wait_done();
    chk(n_irq, 1);
    chk(n_any, 3);
    chk({23'h0, seen}, 32'h0);
    bus(1'b0, IDX_SEQ, 8'h0); chk(rd, 32'h0c);
    // extra written mid-sequence waits for the sequence end
    bus(1'b1, IDX_CTRL, 8'h73);
    bus(1'b1, IDX_EXTRA, 8'h41);
    chk(ana_busy, 1'b1);
    wait_done();
    repeat (700) @(posedge sys_clk);
    chk(n_irq, 2);
    chk(n_any, 6);
    chk({ana_busy, ana_ref, ana_channel}, 32'h11);
    bus(1'b0, IDX_SEQ, 8'h0); chk(rd, 32'h01);
    // skipped inputs, then a walk with no input enabled
    clr_seen();
    bus(1'b1, IDX_MASK, 8'h05);
    bus(1'b1, IDX_SEQ, 8'h03);
    bus(1'b1, IDX_CTRL, 8'h73);
    wait_done();
    chk(n_any, 8);
    chk({23'h0, seen}, 32'h5);
    bus(1'b0, IDX_SEQ, 8'h0); chk(rd, 32'h04);
    bus(1'b1, IDX_MASK, 8'h00);
    bus(1'b1, IDX_SEQ, 8'h05);
    bus(1'b1, IDX_CTRL, 8'h73);
    wait_done();
    chk(n_any, 8);
    bus(1'b0, IDX_SEQ, 8'h0); chk(rd, 32'h06);
    // pin edge and timer event as start sources
    bus(1'b1, IDX_MASK, 8'h01);
    bus(1'b1, IDX_SEQ, 8'h00);
    bus(1'b1, IDX_CTRL, 8'h03);
    bus(1'b0, IDX_HIGH, 8'h0);
    pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    pin <= 1'b0;
    wait_done();
    chk(n_any, 9);
    bus(1'b1, IDX_CTRL, 8'h23);
    bus(1'b0, IDX_HIGH, 8'h0);
    tmr <= 1'b1;
    @(posedge sys_clk);
    tmr <= 1'b0;
    wait_done();
    chk(n_any, 10);
    // audio pulses merged onto the shared channel triggers
    clr_seen();
    aud27 <= 1'b1;
    aud28 <= 1'b1;
    @(posedge sys_clk);
    aud27 <= 1'b0;
    aud28 <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({23'h0, seen}, 32'h180);
    end_sim();
  end
endmodule
